// ==== design/panel_pkg.sv ====
// Purpose: shared types and constants of the front-panel menu controller
// Assumes: 125 MHz system clock
// Notes:   level is held as a magnitude, 10 means -10 dBm; gain in 0.1 dB units
`default_nettype none
package panel_pkg;
	localparam int unsigned CLK_HZ       = 125_000_000;
	localparam int unsigned TIMEOUT_S    = 12;   // idle time that abandons an edit
	localparam int unsigned BOOT_STAGE_MS = 1000; // length of each boot display stage
	localparam int unsigned DEBOUNCE_MS  = 10;
	localparam int unsigned TIMEOUT_CYC  = TIMEOUT_S * CLK_HZ;
	localparam int unsigned BOOT_CYC     = (BOOT_STAGE_MS * (CLK_HZ / 1000));
	localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_MS * (CLK_HZ / 1000));
	localparam logic [4:0]  LVL_MIN_MAG  = 5'd10;  // -10 dBm
	localparam logic [4:0]  LVL_MAX_MAG  = 5'd30;  // -30 dBm
	localparam logic [4:0]  OUT_FLOOR_MAG = 5'd20; // output floor -20 dBm
	localparam logic [9:0]  GAIN_MAX     = 10'd300;
	localparam logic [5:0]  ADDR_MAX     = 6'd31;
	localparam logic [1:0]  IFSEL_MAX    = 2'd2;
	localparam logic [2:0]  FREQ_DIGITS  = 3'd7;
	// register offsets
	localparam logic [3:0]  OFS_CTRL     = 4'h0;
	localparam logic [3:0]  OFS_STATUS   = 4'h4;
	localparam logic [3:0]  OFS_FREQ     = 4'h8;
	localparam logic [3:0]  OFS_LVLGAIN  = 4'hC;
	localparam int unsigned CTRL_OPT_BIT = 0;
	localparam logic        CTRL_RST     = 1'b0;

	typedef enum logic [2:0] {
		ST_LOAD, ST_SEGS, ST_VERSION, ST_IDLE, ST_EDIT, ST_SAVE, ST_DONE
	} state_t;

	typedef enum logic [2:0] {
		M_FREQ, M_LEVEL, M_GAIN, M_MUTE, M_REMOTE, M_EXTREF, M_IFSEL, M_ADDR
	} menu_t;

	typedef struct packed {
		logic [6:0][3:0] freq;                // bcd, digit 6 leftmost
		logic [4:0]      input_level_setting;
		logic [8:0]      gain;
		logic            mute;
		logic            remote;
		logic            extref;
		logic [1:0]      ifsel;
		logic [4:0]      addr;
	} settings_t;

	localparam settings_t SET_RST = '{freq: 28'h3750000, input_level_setting: 5'd20,
		gain: 9'd100, mute: 1'b0, remote: 1'b0, extref: 1'b0, ifsel: 2'd0, addr: 5'd0};

	typedef struct packed {
		state_t          state;
		menu_t           menu;
		logic [2:0]      cur;
		logic            yes;
		settings_t       saved;
		settings_t       edit;
		settings_t       hw;
		logic [30:0]     tmr;
		logic [5:0]      s1;
		logic [5:0]      s2;
		logic [4:0]      stable;
		logic [4:0][20:0] dcnt;
		logic            carrier_mute;
		logic            nvm_wr;
		logic            led_alarm;
		logic            opt_fitted;
		logic [31:0]     rdata;
	} panel_state_t;
endpackage
`default_nettype wire

// ==== design/front_panel_menu_controller.sv ====
// Purpose: front-panel menu controller: switches in, display state, settings out
// Assumes: storage data valid on nvm_rdata when reset releases
// Notes:   serial remote protocol and rf circuitry live elsewhere
//
// The implementer's own choices: the register offsets and the plain strobed port.
`default_nettype none
module front_panel_menu_controller
	import panel_pkg::*;
#(
	parameter int unsigned TMO_CYC = TIMEOUT_CYC,
	parameter int unsigned BOOT_STAGE_CYC = BOOT_CYC,
	parameter int unsigned DB_CYC = DEBOUNCE_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       sw_menu,
	input  wire logic       sw_left,
	input  wire logic       sw_right,
	input  wire logic       sw_up,
	input  wire logic       sw_down,
	input  wire logic       pll_unlock,
	input  wire settings_t  nvm_rdata,
	output var  logic       nvm_wr,
	output var  settings_t  nvm_wdata,
	output var  settings_t  hw_set,
	output var  logic       carrier_mute,
	output var  logic       led_alarm,
	output var  logic       led_mute,
	output var  logic       led_remote,
	output var  state_t     lcd_state,
	output var  menu_t      lcd_menu,
	output var  logic [2:0] lcd_cursor,
	output var  logic       lcd_yes,
	output var  settings_t  lcd_set,
	input  wire logic [3:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [31:0] reg_rdata
);
	panel_state_t     st_reg;
	panel_state_t     st_next;
	logic [4:0]       press;
	logic [4:0]       stb_n;
	logic [4:0][20:0] dcnt_n;
	logic             any_press;
	logic [2:0]       ncur;
	logic [2:0]       fidx;
	logic [3:0]       dig;
	logic [9:0]       gstep;
	logic [9:0]       gnew;
	logic [9:0]       glo;
	logic [9:0]       ghi;
	logic [5:0]       astep;
	logic [5:0]       anew;
	logic             vup;
	logic             vdn;
	logic             last_menu;

	// per-switch debounce; a press is the single cycle the stable level rises
	genvar i;
	generate
		for (i = 0; i < 5; i++) begin : g_db
			always_comb begin
				stb_n[i] = st_reg.stable[i];
				dcnt_n[i] = '0;
				if (st_reg.s2[i] != st_reg.stable[i]) begin
					dcnt_n[i] = st_reg.dcnt[i] + 21'd1;
					if (st_reg.dcnt[i] == 21'(DB_CYC - 1)) begin
						stb_n[i] = st_reg.s2[i];
						dcnt_n[i] = '0;
					end
				end
			end
			assign press[i] = stb_n[i] & ~st_reg.stable[i];
		end
	endgenerate

	assign any_press = |press;
	assign vup = press[3];
	assign vdn = press[4];

	// editable places per menu; the place after them is the return marker
	always_comb begin
		case (st_reg.menu)
			M_FREQ:  ncur = FREQ_DIGITS;
			M_GAIN:  ncur = 3'd3;
			M_ADDR:  ncur = 3'd2;
			default: ncur = 3'd1;
		endcase
	end

	// digit and step arithmetic shared by the vertical switch
	always_comb begin
		fidx = 3'd6 - st_reg.cur;
		dig = st_reg.edit.freq[fidx];
		case (st_reg.cur)
			3'd0:    gstep = 10'd100;
			3'd1:    gstep = 10'd10;
			default: gstep = 10'd1;
		endcase
		gnew = vup ? {1'b0, st_reg.edit.gain} + gstep : {1'b0, st_reg.edit.gain} - gstep;
		ghi = 10'(st_reg.edit.input_level_setting) * 10'd10;
		glo = (st_reg.edit.input_level_setting > OUT_FLOOR_MAG) ?
			10'(st_reg.edit.input_level_setting - OUT_FLOOR_MAG) * 10'd10 : 10'd0;
		astep = (st_reg.cur == 3'd0) ? 6'd10 : 6'd1;
		anew = vup ? {1'b0, st_reg.edit.addr} + astep : {1'b0, st_reg.edit.addr} - astep;
		last_menu = st_reg.opt_fitted ? (st_reg.menu == M_ADDR) : (st_reg.menu == M_IFSEL);
	end

	// whole next state
	always_comb begin
		st_next = st_reg;
		st_next.s1 = {pll_unlock, sw_down, sw_up, sw_right, sw_left, sw_menu};
		st_next.s2 = st_reg.s1;
		st_next.stable = stb_n;
		st_next.dcnt = dcnt_n;
		st_next.nvm_wr = 1'b0;
		st_next.led_alarm = st_reg.s2[5];
		// frequency from the committed copy only; level and gain live
		st_next.hw = st_reg.saved;
		st_next.hw.input_level_setting = st_reg.edit.input_level_setting;
		st_next.hw.gain = st_reg.edit.gain;
		// a pending retune holds the carrier off until the commit lands
		st_next.carrier_mute = st_reg.hw.mute |
			(st_reg.edit.freq != st_reg.saved.freq) | (st_reg.hw.freq != st_reg.saved.freq);
		case (st_reg.state)
			ST_LOAD: begin
				st_next.saved = nvm_rdata;
				st_next.edit = nvm_rdata;
				st_next.tmr = '0;
				st_next.state = ST_SEGS;
			end
			ST_SEGS, ST_VERSION: begin
				st_next.tmr = st_reg.tmr + 31'd1;
				if (st_reg.tmr == 31'(BOOT_STAGE_CYC - 1)) begin
					st_next.tmr = '0;
					st_next.state = (st_reg.state == ST_SEGS) ? ST_VERSION : ST_IDLE;
				end
			end
			ST_IDLE: begin
				st_next.edit = st_reg.saved;
				if (press[0]) begin
					st_next.state = ST_EDIT;
					st_next.menu = M_FREQ;
					st_next.cur = '0;
					st_next.tmr = '0;
				end
			end
			ST_EDIT: begin
				if (press[0]) begin
					st_next.cur = '0;
					st_next.yes = 1'b0;
					if (st_reg.cur == ncur || last_menu)
						st_next.state = ST_SAVE;
					else
						st_next.menu = menu_t'(st_reg.menu + 3'd1);
				end else if (press[1] && st_reg.cur != 3'd0) begin
					st_next.cur = st_reg.cur - 3'd1;
				end else if (press[2] && st_reg.cur < ncur) begin
					st_next.cur = st_reg.cur + 3'd1;
				end else if ((vup || vdn) && st_reg.cur < ncur) begin
					case (st_reg.menu)
						M_FREQ: begin
							if (vup)
								st_next.edit.freq[fidx] = (dig == 4'h9) ? 4'h0 : dig + 4'h1;
							else
								st_next.edit.freq[fidx] = (dig == 4'h0) ? 4'h9 : dig - 4'h1;
						end
						M_LEVEL: begin
							if (vup && st_reg.edit.input_level_setting > LVL_MIN_MAG)
								st_next.edit.input_level_setting =
									st_reg.edit.input_level_setting - 5'd1;
							if (vdn && st_reg.edit.input_level_setting < LVL_MAX_MAG)
								st_next.edit.input_level_setting =
									st_reg.edit.input_level_setting + 5'd1;
						end
						M_GAIN: begin
							// underflow wraps high and fails the upper check
							if (gnew <= GAIN_MAX && gnew <= ghi && gnew >= glo)
								st_next.edit.gain = gnew[8:0];
						end
						M_MUTE:   st_next.edit.mute = ~st_reg.edit.mute;
						M_REMOTE: st_next.edit.remote = ~st_reg.edit.remote;
						M_EXTREF: st_next.edit.extref = ~st_reg.edit.extref;
						M_IFSEL: begin
							if (vup)
								st_next.edit.ifsel = (st_reg.edit.ifsel == IFSEL_MAX) ?
									2'd0 : st_reg.edit.ifsel + 2'd1;
							else
								st_next.edit.ifsel = (st_reg.edit.ifsel == 2'd0) ?
									IFSEL_MAX : st_reg.edit.ifsel - 2'd1;
						end
						M_ADDR: begin
							if (anew <= ADDR_MAX)
								st_next.edit.addr = anew[4:0];
						end
						default: st_next.edit = st_reg.edit;
					endcase
				end
			end
			ST_SAVE: begin
				if (press[0]) begin
					st_next.state = ST_DONE;
					if (st_reg.yes) begin
						st_next.saved = st_reg.edit;
						st_next.nvm_wr = 1'b1;
					end else begin
						st_next.edit = st_reg.saved;
					end
				end else if (vup || vdn) begin
					st_next.yes = ~st_reg.yes;
				end else if (press[1] || press[2]) begin
					st_next.yes = press[1];
				end
			end
			ST_DONE: begin
				if (press[0])
					st_next.state = ST_IDLE;
			end
			default: st_next.state = ST_LOAD;
		endcase
		// inactivity watchdog over the whole session
		if (st_reg.state == ST_EDIT || st_reg.state == ST_SAVE || st_reg.state == ST_DONE) begin
			if (any_press) begin
				st_next.tmr = '0;
			end else if (st_reg.tmr == 31'(TMO_CYC - 1)) begin
				st_next.state = ST_IDLE;
				st_next.edit = st_reg.saved;
				st_next.nvm_wr = 1'b0;
			end else begin
				st_next.tmr = st_reg.tmr + 31'd1;
			end
		end
		// register port: control write and read-back
		if (reg_wr && reg_addr == OFS_CTRL)
			st_next.opt_fitted = reg_wdata[CTRL_OPT_BIT];
		st_next.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				OFS_CTRL:    st_next.rdata = {31'd0, st_reg.opt_fitted};
				OFS_STATUS:  st_next.rdata = {20'd0, st_reg.led_alarm, st_reg.carrier_mute,
					st_reg.yes, st_reg.cur, st_reg.menu, st_reg.state};
				OFS_FREQ:    st_next.rdata = {4'd0, st_reg.saved.freq};
				OFS_LVLGAIN: st_next.rdata = {18'd0, st_reg.hw.input_level_setting,
					st_reg.hw.gain};
				default:     st_next.rdata = '0;
			endcase
		end
	end

	// the single state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '{state: ST_LOAD, menu: M_FREQ, saved: SET_RST, edit: SET_RST,
				hw: SET_RST, opt_fitted: CTRL_RST, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs come straight from the state register
	assign nvm_wr = st_reg.nvm_wr;
	assign nvm_wdata = st_reg.saved;
	assign hw_set = st_reg.hw;
	assign carrier_mute = st_reg.carrier_mute;
	assign led_alarm = st_reg.led_alarm;
	assign led_mute = st_reg.hw.mute;
	assign led_remote = st_reg.hw.remote;
	assign lcd_state = st_reg.state;
	assign lcd_menu = st_reg.menu;
	assign lcd_cursor = st_reg.cur;
	assign lcd_yes = st_reg.yes;
	assign lcd_set = st_reg.edit;
	assign reg_rdata = st_reg.rdata;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_commit_needs_yes: assert property (
		st_next.nvm_wr |-> st_reg.state == ST_SAVE && st_reg.yes && press[0])
		else $error("storage written without confirmed save");

	// the power-up reload is the only other legal way a committed frequency changes
	a_freq_held_back: assert property (
		$past(st_reg.state) != ST_LOAD && st_reg.saved.freq != $past(st_reg.saved.freq)
		|-> $past(st_reg.state) == ST_SAVE)
		else $error("frequency committed outside save prompt");

	a_retune_mutes: assert property (
		st_reg.state == ST_EDIT && st_reg.edit.freq != st_reg.saved.freq |=> carrier_mute)
		else $error("carrier not muted during frequency change");

	a_timeout_reverts: assert property (
		st_reg.state == ST_EDIT && !any_press && st_reg.tmr == 31'(TMO_CYC - 1)
		|=> st_reg.state == ST_IDLE && st_reg.edit == st_reg.saved)
		else $error("idle timeout did not discard edits");

	a_level_range: assert property (
		hw_set.input_level_setting >= LVL_MIN_MAG && hw_set.input_level_setting <= LVL_MAX_MAG)
		else $error("input level out of range");

	a_gain_refused: assert property (
		st_reg.state == ST_EDIT && st_reg.menu == M_GAIN && st_reg.cur < 3'd3 && vup &&
		(gnew > ghi || gnew > GAIN_MAX) |=> $stable(st_reg.edit.gain))
		else $error("gain accepted outside output window");

	a_mute_toggles: assert property (
		st_reg.state == ST_EDIT && st_reg.menu == M_MUTE && st_reg.cur == 3'd0 &&
		(vup || vdn) && !press[0] && !press[1] && !press[2]
		|=> st_reg.edit.mute != $past(st_reg.edit.mute))
		else $error("mute item did not toggle");

	a_alarm_follows: assert property (
		$rose(st_reg.s2[5]) |=> led_alarm)
		else $error("alarm led missed loss of lock");

	a_boot_order: assert property (
		st_reg.state == ST_VERSION |-> $past(st_reg.state) inside {ST_SEGS, ST_VERSION})
		else $error("boot stages out of order");

	a_done_to_idle: assert property (
		st_reg.state == ST_DONE && press[0] |=> st_reg.state == ST_IDLE)
		else $error("menu press after save did not return to default");
endmodule // front_panel_menu_controller
`default_nettype wire

// ==== dv/panel_operator_model.sv ====
// Purpose: operator switches and settings storage facing the menu controller
// Assumes: one request at a time, go pulsed only while busy is low
// Notes:   a press holds HOLD cycles, then releases HOLD cycles, with no bounce
`default_nettype none
module panel_operator_model
	import panel_pkg::*;
#(
	parameter int unsigned HOLD = 10
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic [2:0] key,
	output var  logic       busy,
	output var  logic [4:0] sw,
	input  wire logic       nvm_wr,
	input  wire settings_t  nvm_wdata,
	output var  settings_t  nvm_rdata
);
	logic [7:0] cnt_reg;
	logic [2:0] key_reg;

	// storage ignores reset so that it outlives a power cycle
	initial nvm_rdata = SET_RST;
	always @(posedge sys_clk) begin
		if (nvm_wr === 1'b1) nvm_rdata <= nvm_wdata;
	end

	// one actuation: a pressed half then a released half
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 8'h00;
			key_reg <= 3'h0;
		end else if (go && cnt_reg == 8'h00) begin
			cnt_reg <= 8'(2 * HOLD);
			key_reg <= key;
		end else if (cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end
	end
	assign busy = (cnt_reg != 8'h00);
	assign sw   = (cnt_reg > 8'(HOLD)) ? 5'(5'h01 << key_reg) : 5'h00;
endmodule // panel_operator_model
`default_nettype wire

// ==== dv/test_front_panel_menu_controller.sv ====
// Purpose: self-checking bench of the front-panel menu controller
// Assumes: short counts for timeout, boot stages and debounce
// Notes:   each press takes about twenty cycles, well under the timeout
`default_nettype none
module test_front_panel_menu_controller
	import panel_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned TMO = 200;
	localparam logic [2:0] K_MENU = 3'h0, K_LEFT = 3'h1, K_RIGHT = 3'h2;
	localparam logic [2:0] K_UP = 3'h3, K_DOWN = 3'h4;
	logic        sys_clk = 1'b0, rst = 1'b1, pll_unlock = 1'b0, go = 1'b0, busy;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, nvm_wr, carrier_mute, lcd_yes;
	logic        led_alarm, led_mute, led_remote;
	logic [2:0]  key = 3'h0, lcd_cursor;
	logic [4:0]  sw;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
	settings_t   nvm_rdata, nvm_wdata, hw_set, lcd_set;
	state_t      lcd_state;
	menu_t       lcd_menu;
	int          n_mismatch = 0, total_checks = 0, n_wr = 0;

	front_panel_menu_controller #(.TMO_CYC(TMO), .BOOT_STAGE_CYC(20), .DB_CYC(4))
	i_front_panel_menu_controller (.sys_clk(sys_clk), .rst(rst), .sw_menu(sw[0]),
		.sw_left(sw[1]), .sw_right(sw[2]), .sw_up(sw[3]), .sw_down(sw[4]),
		.pll_unlock(pll_unlock), .nvm_rdata(nvm_rdata), .nvm_wr(nvm_wr),
		.nvm_wdata(nvm_wdata), .hw_set(hw_set), .carrier_mute(carrier_mute),
		.led_alarm(led_alarm), .led_mute(led_mute), .led_remote(led_remote),
		.lcd_state(lcd_state), .lcd_menu(lcd_menu), .lcd_cursor(lcd_cursor),
		.lcd_yes(lcd_yes), .lcd_set(lcd_set), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	panel_operator_model #(.HOLD(10)) i_panel_operator_model (.sys_clk(sys_clk),
		.rst(rst), .go(go), .key(key), .busy(busy), .sw(sw), .nvm_wr(nvm_wr),
		.nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata));

	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	// storage writes are counted to prove commits happen only on yes
	always @(posedge sys_clk) begin
		if (nvm_wr === 1'b1) n_wr <= n_wr + 1;
	end

	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic press(input logic [2:0] k, input int n);
		for (int j = 0; j < n; j++) begin
			@(posedge sys_clk) go <= 1'b1;
			key <= k;
			@(posedge sys_clk) go <= 1'b0;
			// busy is only seen high one edge after the model has taken go
			@(posedge sys_clk);
			for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge sys_clk);
		end
		#1;
	endtask
	// register cycles: one strobe cycle, read data in the following cycle
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk) reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk) reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge sys_clk) reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk) reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic boot();
		@(posedge sys_clk) rst <= 1'b1;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (10) @(posedge sys_clk);
		#1 chk(lcd_state === ST_SEGS, "not all segments");
		repeat (20) @(posedge sys_clk);
		#1 chk(lcd_state === ST_VERSION, "no version stage");
		repeat (20) @(posedge sys_clk);
		#1 chk(lcd_state === ST_IDLE, "no default display");
		$display("test boot done");
	endtask
	task automatic t_freq();
		press(K_MENU, 1);
		chk(lcd_state === ST_EDIT && lcd_menu === M_FREQ, "no freq menu");
		press(K_UP, 1);
		chk(lcd_set.freq === 28'h4750000, "digit not raised once");
		chk(hw_set.freq === 28'h3750000, "freq applied early");
		chk(carrier_mute === 1'b1, "carrier not muted");
		press(K_LEFT, 1);
		chk(lcd_cursor === 3'd0, "cursor left of first place");
		press(K_RIGHT, 7);
		chk(lcd_cursor === 3'd7, "cursor not on return mark");
		press(K_MENU, 1);
		chk(lcd_state === ST_SAVE && lcd_yes === 1'b0, "no save prompt");
		press(K_UP, 1);
		press(K_MENU, 1);
		chk(lcd_state === ST_DONE && n_wr == 1, "yes not committed");
		chk(hw_set.freq === 28'h4750000 && carrier_mute === 1'b0, "freq not applied");
		press(K_MENU, 1);
		chk(lcd_state === ST_IDLE, "no return to default");
		rd(OFS_FREQ, d);
		chk(d[27:0] === 28'h4750000, "freq register");
		$display("test freq done");
	endtask
	task automatic t_gain();
		press(K_MENU, 3);
		chk(lcd_menu === M_GAIN && lcd_cursor === 3'd0, "no gain menu");
		press(K_UP, 1);
		chk(hw_set.gain === 9'd200, "10 dB step not live");
		press(K_UP, 1);
		chk(hw_set.gain === 9'd200, "output above 0 dBm accepted");
		press(K_RIGHT, 1);
		press(K_DOWN, 1);
		chk(hw_set.gain === 9'd190, "1 dB step");
		press(K_RIGHT, 1);
		press(K_DOWN, 1);
		chk(hw_set.gain === 9'd189, "0.1 dB step");
		press(K_RIGHT, 1);
		press(K_MENU, 2);
		chk(hw_set.gain === 9'd100 && n_wr == 1, "no did not restore");
		press(K_MENU, 1);
		$display("test gain done");
	endtask
	task automatic t_level();
		press(K_MENU, 2);
		chk(lcd_menu === M_LEVEL, "no level menu");
		press(K_UP, 1);
		chk(hw_set.input_level_setting === 5'h13, "level step");
		press(K_UP, 11);
		chk(hw_set.input_level_setting === 5'h0A, "level range");
		chk(lcd_state === ST_EDIT, "presses did not hold session");
		repeat (150) @(posedge sys_clk);
		#1 chk(lcd_state === ST_EDIT, "timeout too early");
		repeat (80) @(posedge sys_clk);
		#1 chk(lcd_state === ST_IDLE && hw_set.input_level_setting === 5'd20, "no timeout");
		chk(n_wr == 1, "timeout stored");
		$display("test level done");
	endtask
	task automatic t_mute();
		press(K_MENU, 4);
		chk(lcd_menu === M_MUTE, "no mute menu");
		press(K_UP, 1);
		chk(lcd_set.mute === 1'b1, "up no toggle");
		press(K_DOWN, 1);
		chk(lcd_set.mute === 1'b0, "down no toggle");
		press(K_DOWN, 1);
		press(K_MENU, 1);
		press(K_UP, 1);
		press(K_MENU, 3);
		chk(lcd_state === ST_SAVE, "past last item");
		press(K_UP, 1);
		press(K_MENU, 1);
		chk(led_mute === 1'b1 && carrier_mute === 1'b1, "mute led");
		chk(led_remote === 1'b1 && n_wr == 2, "remote led");
		press(K_MENU, 1);
		$display("test mute done");
	endtask
	task automatic t_misc();
		@(posedge sys_clk) pll_unlock <= 1'b1;
		repeat (5) @(posedge sys_clk);
		#1 chk(led_alarm === 1'b1, "no alarm");
		rd(OFS_STATUS, d);
		chk(d[11] === 1'b1 && d[2:0] === 3'd3, "status");
		@(posedge sys_clk) pll_unlock <= 1'b0;
		wr(OFS_CTRL, 32'h1);
		rd(OFS_CTRL, d);
		chk(d[0] === 1'b1, "ctrl readback");
		rd(4'h2, d);
		chk(d === 32'h0, "unmapped read");
		chk(led_alarm === 1'b0, "alarm stuck");
		// the address menu exists only with the option bit set; try the upper range end with both step sizes
		press(K_MENU, 8);
		chk(lcd_menu === M_ADDR, "no address menu");
		press(K_UP, 4);
		chk(lcd_set.addr === 5'h1E, "tens step or range");
		press(K_RIGHT, 1);
		press(K_UP, 2);
		chk(lcd_set.addr === 5'h1F, "address above 31 accepted");
		press(K_MENU, 1);
		chk(lcd_state === ST_SAVE, "address not last item");
		press(K_MENU, 2);
		chk(lcd_state === ST_IDLE && n_wr == 2 && hw_set.addr === 5'h00, "no saved addr");
		boot();
		chk(hw_set.freq === 28'h4750000 && hw_set.mute === 1'b1, "not reloaded");
		$display("test power done");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		boot();
		t_freq();
		t_gain();
		t_level();
		t_mute();
		t_misc();
		summarize();
	end
	// the whole run takes a few thousand cycles
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_mismatch++;
		summarize();
	end
endmodule // test_front_panel_menu_controller
`default_nettype wire
